// ==== shr_buffer_model.sv ====
// Partner model: one-event buffer and the token ring return path
`timescale 1ns/1ps
module shr_buffer_model (
	input  wire logic         clk_in,
	input  wire logic         load_in,
	input  wire logic [127:0] w0_in,
	input  wire logic [127:0] w1_in,
	input  wire logic [127:0] w2_in,
	input  wire logic         read_n_in,
	input  wire logic         token_in,
	input  wire logic         ring_in,
	output logic              pending_out,
	output logic [127:0]      data_out,
	output logic              token_ret_out
);
	logic [1:0]   k_r = 2'h0;
	logic [127:0] last_r = '0;
	logic [4:0]   ring_r = 5'h00;
	initial pending_out = 1'h0;
	// Oldest word first; released bus shows inverted data
	always_comb begin
		data_out = (k_r == 2'h0) ? w0_in : (k_r == 2'h1) ? w1_in : w2_in;
		if (read_n_in) data_out = ~last_r;
	end
	// Event leaves after third word; ring echoes tokens
	always @(posedge clk_in) begin
		k_r <= read_n_in ? 2'h0 : k_r + 2'h1;
		if (!read_n_in) last_r <= data_out;
		if (load_in) pending_out <= 1'h1;
		else if (!read_n_in && k_r == 2'h2) pending_out <= 1'h0;
		ring_r <= {ring_r[3:0], token_in & ring_in};
	end
	assign token_ret_out = |ring_r[4:3];
endmodule // shr_buffer_model

// ==== shr_pkg.sv ====
// Shared constants, codes and helpers for the sparse hit readout chain
package shr_pkg;

	// Event and channel geometry
	localparam int NUM_CH  = 128;
	localparam int CH_W    = 7;
	localparam int HIT_W   = 3;
	localparam int SAMPLES = 3;
	localparam int POS_W   = 4;

	// Controller counters and event tag store
	localparam int TRIG_W    = 4;
	localparam int BCX_W     = 8;
	localparam int TAG_W     = 12;
	localparam int TAG_DEPTH = 24;

	// Selection criteria codes
	localparam logic [1:0] CRIT_ANY    = 2'h0;
	localparam logic [1:0] CRIT_CENTRE = 2'h1;
	localparam logic [1:0] CRIT_EDGE   = 2'h2;
	localparam logic [1:0] CRIT_ALL    = 2'h3;

	// Record prefixes on the serial data output
	localparam logic [1:0] REC_ERR   = 2'h1;
	localparam logic [1:0] REC_ADDR  = 2'h2;
	localparam logic [1:0] REC_NEIGH = 2'h3;

	// Error codes, higher value is higher priority
	localparam logic [2:0] ERR_NONE    = 3'h0;
	localparam logic [2:0] ERR_NO_DATA = 3'h1;
	localparam logic [2:0] ERR_OVERRUN = 3'h2;
	localparam logic [2:0] ERR_FAULT   = 3'h4;

	// Frame layout and timing counts in clock cycles
	localparam int         SHIFT_W       = 16;
	localparam int         CTRL_SHIFT_W  = 13;
	localparam logic [4:0] HEAD_LEN      = 5'h05;
	localparam logic [4:0] ADDR_LEN      = 5'h0c;
	localparam logic [4:0] SHORT_LEN     = 5'h05;
	localparam logic [4:0] TRAILER_LEN   = 5'h04;
	localparam logic [4:0] TOKEN_LEAD    = 5'h02;
	localparam logic [3:0] START_DELAY   = 4'h2;
	localparam logic [3:0] CTRL_HEAD_LEN = 4'hd;

	// Criterion test, pattern bit 2 is the oldest sample
	function automatic logic crit_match(input logic [HIT_W-1:0] pat, input logic [1:0] mode);
		logic ok;
		ok = 1'b0;
		unique case (mode)
			CRIT_ANY:    ok = |pat;
			CRIT_CENTRE: ok = pat[1];
			CRIT_EDGE:   ok = pat[1] & ~pat[2];
			CRIT_ALL:    ok = 1'b1;
		endcase
		return ok;
	endfunction

	// Highest priority pending error
	function automatic logic [2:0] err_pick(input logic fault, input logic over, input logic none);
		logic [2:0] code;
		code = ERR_NONE;
		if (fault) begin
			code = ERR_FAULT;
		end else if (over) begin
			code = ERR_OVERRUN;
		end else if (none) begin
			code = ERR_NO_DATA;
		end
		return code;
	endfunction

endpackage

// ==== shr_readout_chain.sv ====
// Sparse readout chain: token readout, serialiser and readout controller
`timescale 1ns/1ps
module shr_readout_chain (
	input  wire logic                        sys_clk_in,
	input  wire logic                        rst_n_in,
	input  wire logic                        clear_n_in,
	input  wire logic                        soft_reset_n_in,
	input  wire logic                        crossing_reset_in,
	input  wire logic                        trigger_level_one_in,
	input  wire logic [1:0]                  selection_criteria_in,
	input  wire logic                        controller_role_in,
	input  wire logic [shr_pkg::POS_W-1:0]   chip_position_low_in,
	input  wire logic [shr_pkg::NUM_CH-1:0]  buffer_data_in,
	input  wire logic                        event_pending_in,
	input  wire logic                        buffer_overrun_in,
	input  wire logic                        buffer_error_in,
	input  wire logic                        token_in,
	input  wire logic                        chain_data_in,
	output logic                             buffer_read_n_out,
	output logic                             serial_data_out,
	output logic                             token_out,
	output logic                             readout_done_out,
	output logic                             optical_serial_out
);
	import shr_pkg::*;

	typedef enum logic [2:0] {RD_IDLE, RD_WAIT, RD_SHIFT, RD_PICK, RD_FINISH} shr_rd_t;
	typedef enum logic [1:0] {CT_IDLE, CT_POP, CT_HEAD, CT_RING} shr_ct_t;

	logic clr_n;
	logic counter_clr_n;
	logic tok_s1_r;
	logic tok_s2_r;
	logic tok_s3_r;
	logic dat_s1_r;
	logic dat_s2_r;
	logic token_edge;
	logic token_start;

	logic              sc_read_n;
	logic              sc_loaded;
	logic              hit_valid;
	logic [HIT_W-1:0]  hit_pattern;
	logic [CH_W-1:0]   channel_index;
	logic              neighbour_flag;
	logic              scan_done;
	logic              scan_start_r;
	logic              scan_advance_r;
	logic              scan_release_r;

	shr_rd_t              rd_state_r;
	logic [3:0]           delay_cnt_r;
	logic [SHIFT_W-1:0]   shift_r;
	logic [4:0]           bits_left_r;
	logic                 last_rec_r;
	logic                 no_data_r;
	logic                 fault_seen_r;
	logic                 over_seen_r;
	logic                 err_sent_r;
	logic [2:0]           err_code;
	logic                 pass_now;
	logic                 lead_now;

	logic [TRIG_W-1:0]       trig_cnt_r;
	logic [BCX_W-1:0]        bcx_cnt_r;
	logic [TAG_W-1:0]        tag_data;
	logic                    tag_empty;
	shr_ct_t                 ct_state_r;
	logic [CTRL_SHIFT_W-1:0] ct_shift_r;
	logic [3:0]              ct_left_r;
	logic                    launch_r;
	logic                    tag_pop;

	// Scanner clear combines hard reset and block clear
	assign clr_n         = rst_n_in & clear_n_in;
	assign counter_clr_n = rst_n_in & soft_reset_n_in;

	// Neighbour token and data pins pass two flip-flops
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			tok_s1_r <= 1'b0;
			tok_s2_r <= 1'b0;
			tok_s3_r <= 1'b0;
			dat_s1_r <= 1'b0;
			dat_s2_r <= 1'b0;
		end else begin
			tok_s1_r <= token_in;
			tok_s2_r <= tok_s1_r;
			tok_s3_r <= tok_s2_r;
			dat_s1_r <= chain_data_in;
			dat_s2_r <= dat_s1_r;
		end
	end

	// Ring token arrival; a controller starts its own chip on launch
	assign token_edge  = tok_s2_r & ~tok_s3_r;
	assign token_start = controller_role_in ? launch_r : token_edge;

	shr_scanner u_scanner (
		.clk_in             (sys_clk_in),
		.rst_n_in           (clr_n),
		.fetch_req_in       (event_pending_in),
		.buf_word_in        (buffer_data_in),
		.mode_in            (selection_criteria_in),
		.scan_start_in      (scan_start_r),
		.scan_advance_in    (scan_advance_r),
		.scan_release_in    (scan_release_r),
		.buf_read_n_out     (sc_read_n),
		.loaded_out         (sc_loaded),
		.hit_valid_out      (hit_valid),
		.hit_pattern_out    (hit_pattern),
		.channel_index_out  (channel_index),
		.neighbour_flag_out (neighbour_flag),
		.scan_done_out      (scan_done)
	);

	// Read strobe already comes from a scanner flop
	assign buffer_read_n_out = sc_read_n;

	// Pending error priority
	// one code, highest priority
	assign err_code = err_pick(fault_seen_r, over_seen_r, no_data_r);

	// Token pass cases
	// empty chip passes at once
	assign pass_now = (rd_state_r == RD_IDLE) & token_start & ~sc_loaded & ~event_pending_in;
	assign lead_now = (rd_state_r == RD_SHIFT) & last_rec_r & (bits_left_r == TOKEN_LEAD);

	// Readout sequencer and serialiser
	always_ff @(posedge sys_clk_in) begin
		if (!clr_n) begin
			rd_state_r     <= RD_IDLE;
			delay_cnt_r    <= '0;
			shift_r        <= '0;
			bits_left_r    <= '0;
			last_rec_r     <= 1'b0;
			no_data_r      <= 1'b0;
			err_sent_r     <= 1'b0;
			scan_start_r   <= 1'b0;
			scan_advance_r <= 1'b0;
			scan_release_r <= 1'b0;
		end else begin
			scan_start_r   <= 1'b0;
			scan_advance_r <= 1'b0;
			scan_release_r <= 1'b0;
			unique case (rd_state_r)
				RD_IDLE: begin
					if (token_start && (sc_loaded || event_pending_in)) begin
						rd_state_r  <= RD_WAIT;
						delay_cnt_r <= '0;
						no_data_r   <= ~sc_loaded;
						err_sent_r  <= 1'b0;
						last_rec_r  <= 1'b0;
					end
				end
				RD_WAIT: begin
					// fixed delay, then start scan and header
					delay_cnt_r <= delay_cnt_r + 4'h1;
					if (delay_cnt_r == START_DELAY - 4'h1) begin
						scan_start_r <= ~no_data_r;
						shift_r      <= {1'b1, chip_position_low_in, 11'h000};
						bits_left_r  <= HEAD_LEN;
						rd_state_r   <= RD_SHIFT;
					end
				end
				RD_SHIFT: begin
					shift_r     <= {shift_r[SHIFT_W-2:0], 1'b0};
					bits_left_r <= bits_left_r - 5'h01;
					if (bits_left_r == 5'h01) begin
						rd_state_r <= last_rec_r ? RD_FINISH : RD_PICK;
					end
				end
				RD_PICK: begin
					rd_state_r <= RD_SHIFT;
					if (err_code != ERR_NONE && !err_sent_r) begin
						shift_r     <= {REC_ERR, err_code, 11'h000};
						bits_left_r <= SHORT_LEN;
						err_sent_r  <= 1'b1;
					end else if (hit_valid && !no_data_r) begin
						// address only at start of a run
						if (neighbour_flag) begin
							shift_r     <= {REC_NEIGH, hit_pattern, 11'h000};
							bits_left_r <= SHORT_LEN;
						end else begin
							shift_r     <= {REC_ADDR, channel_index, hit_pattern, 4'h0};
							bits_left_r <= ADDR_LEN;
						end
						scan_advance_r <= 1'b1;
					end else if (scan_done || no_data_r) begin
						shift_r     <= '0;
						bits_left_r <= TRAILER_LEN;
						last_rec_r  <= 1'b1;
					end else begin
						rd_state_r <= RD_PICK;
					end
				end
				RD_FINISH: begin
					scan_release_r <= ~no_data_r;
					rd_state_r     <= RD_IDLE;
				end
			endcase
		end
	end

	// Error sightings held for the frame in progress
	always_ff @(posedge sys_clk_in) begin
		if (!clr_n) begin
			fault_seen_r <= 1'b0;
			over_seen_r  <= 1'b0;
		end else if (rd_state_r == RD_IDLE) begin
			fault_seen_r <= 1'b0;
			over_seen_r  <= 1'b0;
		end else begin
			fault_seen_r <= fault_seen_r | buffer_error_in;
			over_seen_r  <= over_seen_r | buffer_overrun_in;
		end
	end

	// Serial data, token and completion outputs
	always_ff @(posedge sys_clk_in) begin
		if (!clr_n) begin
			serial_data_out  <= 1'b0;
			token_out        <= 1'b0;
			readout_done_out <= 1'b0;
		end else begin
			serial_data_out  <= (rd_state_r == RD_SHIFT) & shift_r[SHIFT_W-1];
			token_out        <= pass_now | lead_now;
			readout_done_out <= (rd_state_r == RD_FINISH) | pass_now;
		end
	end

	// Trigger counter
	always_ff @(posedge sys_clk_in) begin
		if (!counter_clr_n) begin
			trig_cnt_r <= '0;
		end else if (trigger_level_one_in) begin
			trig_cnt_r <= trig_cnt_r + TRIG_W'(1);
		end
	end

	// Crossing counter
	always_ff @(posedge sys_clk_in) begin
		if (!counter_clr_n || crossing_reset_in) begin
			bcx_cnt_r <= '0;
		end else begin
			bcx_cnt_r <= bcx_cnt_r + BCX_W'(1);
		end
	end

	shr_tag_fifo #(
		.WIDTH (TAG_W),
		.DEPTH (TAG_DEPTH)
	) u_tag_fifo (
		.clk_in       (sys_clk_in),
		.rst_n_in     (counter_clr_n),
		.push_in      (trigger_level_one_in & controller_role_in),
		.push_data_in ({trig_cnt_r, bcx_cnt_r}),
		.pop_in       (tag_pop),
		.pop_data_out (tag_data),
		.empty_out    (tag_empty),
		.full_out     ()
	);

	assign tag_pop = (ct_state_r == CT_IDLE) & controller_role_in & ~tag_empty & clr_n;

	// Controller: tag header, token launch, ring relay
	always_ff @(posedge sys_clk_in) begin
		if (!clr_n || !controller_role_in) begin
			ct_state_r <= CT_IDLE;
			ct_shift_r <= '0;
			ct_left_r  <= '0;
			launch_r   <= 1'b0;
		end else begin
			launch_r <= 1'b0;
			unique case (ct_state_r)
				CT_IDLE: begin
					if (!tag_empty) begin
						ct_state_r <= CT_POP;
					end
				end
				CT_POP: begin
					// header is start bit plus tag
					ct_shift_r <= {1'b1, tag_data};
					ct_left_r  <= CTRL_HEAD_LEN;
					ct_state_r <= CT_HEAD;
				end
				CT_HEAD: begin
					ct_shift_r <= {ct_shift_r[CTRL_SHIFT_W-2:0], 1'b0};
					ct_left_r  <= ct_left_r - 4'h1;
					if (ct_left_r == 4'h1) begin
						launch_r   <= 1'b1;
						ct_state_r <= CT_RING;
					end
				end
				CT_RING: begin
					if (token_edge) begin
						ct_state_r <= CT_IDLE;
					end
				end
			endcase
		end
	end

	// Optical output: header, then own and chain data
	always_ff @(posedge sys_clk_in) begin
		if (!clr_n || !controller_role_in) begin
			optical_serial_out <= 1'b0;
		end else begin
			unique case (ct_state_r)
				CT_HEAD: optical_serial_out <= ct_shift_r[CTRL_SHIFT_W-1];
				CT_RING: optical_serial_out <= dat_s2_r | serial_data_out;
				default: optical_serial_out <= 1'b0;
			endcase
		end
	end

endmodule // shr_readout_chain

// ==== shr_readout_chain_assertions.sv ====
// Port timing checker for the sparse hit readout chain
`timescale 1ns/1ps
module shr_readout_chain_checker (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic event_pending_in,
	input wire logic token_in,
	input wire logic controller_role_in,
	input wire logic buffer_read_n_out,
	input wire logic serial_data_out,
	input wire logic token_out,
	input wire logic readout_done_out,
	input wire logic optical_serial_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// Fetch only answers a pending event
	fetch_pending_a: assert property ($fell(buffer_read_n_out) |-> $past(event_pending_in))
		else $error("Strobe fell with no pending event");
	strobe_three_a: assert property ($fell(buffer_read_n_out) |->
		!buffer_read_n_out [*3] ##1 buffer_read_n_out)
		else $error("Strobe not low for exactly three cycles");
	event_held_a: assert property ($rose(buffer_read_n_out) |-> buffer_read_n_out [*8])
		else $error("Second fetch while an event is held");
	// Token and completion are single pulses, completion follows token
	token_pulse_a: assert property (token_out |=> !token_out)
		else $error("Token output longer than one cycle");
	done_pulse_a: assert property (readout_done_out |=> !readout_done_out)
		else $error("Completion pulse longer than one cycle");
	token_done_a: assert property (token_out |-> ##[0:4] readout_done_out)
		else $error("No completion pulse after token");
	// Serial line rests low after a readout until a token
	rest_low_a: assert property (readout_done_out && !token_in ##1
		!token_in [*6] |-> !serial_data_out)
		else $error("Serial output active without token");
	role_idle_a: assert property (!controller_role_in &&
		$past(!controller_role_in) |-> !optical_serial_out)
		else $error("Optical output active outside controller role");
endmodule // shr_readout_chain_checker

bind shr_readout_chain shr_readout_chain_checker i_chk (
	.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .event_pending_in(event_pending_in),
	.token_in(token_in), .controller_role_in(controller_role_in),
	.buffer_read_n_out(buffer_read_n_out), .serial_data_out(serial_data_out),
	.token_out(token_out), .readout_done_out(readout_done_out),
	.optical_serial_out(optical_serial_out)
);

// ==== shr_scanner.sv ====
// Hit scanner: fetches one event and steps through matching channels
`timescale 1ns/1ps
module shr_scanner (
	input  wire logic                      clk_in,
	input  wire logic                      rst_n_in,
	input  wire logic                      fetch_req_in,
	input  wire logic [shr_pkg::NUM_CH-1:0] buf_word_in,
	input  wire logic [1:0]                mode_in,
	input  wire logic                      scan_start_in,
	input  wire logic                      scan_advance_in,
	input  wire logic                      scan_release_in,
	output logic                           buf_read_n_out,
	output logic                           loaded_out,
	output logic                           hit_valid_out,
	output logic [shr_pkg::HIT_W-1:0]      hit_pattern_out,
	output logic [shr_pkg::CH_W-1:0]       channel_index_out,
	output logic                           neighbour_flag_out,
	output logic                           scan_done_out
);
	import shr_pkg::*;

	typedef enum logic [2:0] {SC_IDLE, SC_FETCH, SC_LOADED, SC_SEARCH, SC_PRESENT, SC_DONE} shr_sc_t;

	shr_sc_t          state_r;
	logic [NUM_CH-1:0] word_r [SAMPLES];
	logic [1:0]        fetch_cnt_r;
	logic [CH_W-1:0]   idx_r;
	logic [CH_W-1:0]   prev_r;
	logic              have_prev_r;
	logic [HIT_W-1:0]  cur_pat;

	// Per-channel three-sample word, oldest sample in bit 2
	// regroup into channel words
	assign cur_pat    = {word_r[0][idx_r], word_r[1][idx_r], word_r[2][idx_r]};
	assign loaded_out = (state_r == SC_LOADED);

	// Event capture: strobe low for three cycles, one word each
	always_ff @(posedge clk_in) begin
		if (state_r == SC_FETCH) begin
			word_r[fetch_cnt_r] <= buf_word_in;
		end
	end

	// Scan sequencing
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_r            <= SC_IDLE;
			fetch_cnt_r        <= '0;
			idx_r              <= '0;
			prev_r             <= '0;
			have_prev_r        <= 1'b0;
			buf_read_n_out     <= 1'b1;
			hit_valid_out      <= 1'b0;
			hit_pattern_out    <= '0;
			channel_index_out  <= '0;
			neighbour_flag_out <= 1'b0;
			scan_done_out      <= 1'b0;
		end else begin
			unique case (state_r)
				SC_IDLE: begin
					if (fetch_req_in) begin
						state_r        <= SC_FETCH;
						fetch_cnt_r    <= '0;
						buf_read_n_out <= 1'b0;
					end
				end
				SC_FETCH: begin
					fetch_cnt_r <= fetch_cnt_r + 2'h1;
					if (fetch_cnt_r == 2'(SAMPLES-1)) begin
						buf_read_n_out <= 1'b1;
						state_r        <= SC_LOADED;
					end
				end
				SC_LOADED: begin
					if (scan_start_in) begin
						state_r     <= SC_SEARCH;
						idx_r       <= '0;
						have_prev_r <= 1'b0;
					end
				end
				SC_SEARCH: begin
					if (crit_match(cur_pat, mode_in)) begin
						state_r           <= SC_PRESENT;
						hit_valid_out     <= 1'b1;
						hit_pattern_out   <= cur_pat;
						channel_index_out <= idx_r;
						neighbour_flag_out <= have_prev_r && (idx_r == prev_r + CH_W'(1));
						prev_r            <= idx_r;
						have_prev_r       <= 1'b1;
					end else if (idx_r == CH_W'(NUM_CH-1)) begin
						state_r       <= SC_DONE;
						scan_done_out <= 1'b1;
					end else begin
						idx_r <= idx_r + CH_W'(1);
					end
				end
				SC_PRESENT: begin
					if (scan_advance_in) begin
						hit_valid_out      <= 1'b0;
						neighbour_flag_out <= 1'b0;
						if (idx_r == CH_W'(NUM_CH-1)) begin
							state_r       <= SC_DONE;
							scan_done_out <= 1'b1;
						end else begin
							idx_r   <= idx_r + CH_W'(1);
							state_r <= SC_SEARCH;
						end
					end
				end
				SC_DONE: begin
					if (scan_release_in) begin
						state_r       <= SC_IDLE;
						scan_done_out <= 1'b0;
					end
				end
			endcase
		end
	end

endmodule // shr_scanner

// ==== shr_tag_fifo.sv ====
// Event tag FIFO with registered read data
`timescale 1ns/1ps
module shr_tag_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 24
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             push_in,
	input  wire logic [WIDTH-1:0] push_data_in,
	input  wire logic             pop_in,
	output logic      [WIDTH-1:0] pop_data_out,
	output logic                  empty_out,
	output logic                  full_out
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] DEPTH_CNT = (PW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0]    wr_ptr_r;
	logic [PW-1:0]    rd_ptr_r;
	logic [PW:0]      count_r;
	logic             do_push;
	logic             do_pop;

	// Pointer step with wrap at the last location
	function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
		return (p == PW'(DEPTH-1)) ? '0 : p + PW'(1);
	endfunction

	// Full refuses pushes, empty refuses pops
	assign do_push   = push_in & ~full_out;
	assign do_pop    = pop_in & ~empty_out;
	assign empty_out = (count_r == '0);
	assign full_out  = (count_r == DEPTH_CNT);

	// Storage write
	always_ff @(posedge clk_in) begin
		if (do_push) begin
			mem_r[wr_ptr_r] <= push_data_in;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_r <= ptr_step(wr_ptr_r);
			end
			if (do_pop) begin
				rd_ptr_r <= ptr_step(rd_ptr_r);
			end
			count_r <= count_r + (PW+1)'(do_push) - (PW+1)'(do_pop);
		end
	end

	// Read data register
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pop_data_out <= '0;
		end else if (do_pop) begin
			pop_data_out <= mem_r[rd_ptr_r];
		end
	end

endmodule // shr_tag_fifo

// ==== test_sparse_hit_readout_chain.sv ====
// Testbench for the sparse hit readout chain
`timescale 1ns/1ps
module test_sparse_hit_readout_chain;
	logic         clk = 1'h0;
	logic         rst_n, clr_n, soft_n, cr, trig, role, ld, tok, ov, berr;
	logic [1:0]   crit;
	logic [127:0] w0, w1, w2, bdata;
	logic         rd_n, pend, ser, tout, done, opt, tret;
	logic [63:0]  sbuf;
	logic [25:0]  obuf;
	int           k, sn, on, failures, cmp_count;
	always #2.5 clk = ~clk;
	shr_buffer_model i_buf (.clk_in(clk), .load_in(ld), .w0_in(w0), .w1_in(w1), .w2_in(w2),
		.read_n_in(rd_n), .token_in(tout), .ring_in(role), .pending_out(pend),
		.data_out(bdata), .token_ret_out(tret));
	shr_readout_chain i_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .clear_n_in(clr_n),
		.soft_reset_n_in(soft_n), .crossing_reset_in(cr), .trigger_level_one_in(trig),
		.selection_criteria_in(crit), .controller_role_in(role), .chip_position_low_in(4'ha),
		.buffer_data_in(bdata), .event_pending_in(pend), .buffer_overrun_in(ov),
		.buffer_error_in(berr), .token_in(tok | tret), .chain_data_in(1'h0),
		.buffer_read_n_out(rd_n), .serial_data_out(ser), .token_out(tout),
		.readout_done_out(done), .optical_serial_out(opt));
	// Capture serial bits from the first set bit, optical bits from the start bit of each 13-bit header
	always @(posedge clk) begin
		if (sn < 64 && (sn > 0 || ser)) begin
			sbuf[63-sn] = ser;
			sn = sn + 1;
		end
		if (on < 26 && (on % 13 != 0 || opt)) begin
			obuf[25-on] = opt;
			on = on + 1;
		end
	end
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		if (failures == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Expected frame: header, error, address and neighbour records
	function automatic logic [63:0] exp_frame(input logic [1:0] m, input logic [2:0] e);
		logic [127:0] f;
		logic [2:0]   p;
		logic         ok, prev;
		int           n, pn, pi;
		f = '0;
		f[127-:5] = {1'h1, 4'ha};
		n = 6;
		pn = 0;
		pi = -1;
		prev = 1'h0;
		if (e != 3'h0) begin
			f[127-n-:5] = {2'h1, e};
			n += 6;
		end
		for (int i = 0; i < 128; i++) begin
			p = {w0[i], w1[i], w2[i]};
			ok = (m == 2'h0) ? |p : (m == 2'h1) ? p[1] : (m == 2'h2) ? p[1] & !p[2] : 1'h1;
			// Scanner steps one channel a cycle, so a far hit starts late
			if (ok) begin
				n = (n < pn + 2 + i - pi) ? pn + 2 + i - pi : n;
				pn = n;
				pi = i;
			end
			if (ok && n < 100 && prev) begin
				f[127-n-:5] = {2'h3, p};
				n += 6;
			end else if (ok && n < 100) begin
				f[127-n-:12] = {2'h2, i[6:0], p};
				n += 13;
			end
			prev = ok;
		end
		return f[127:64];
	endfunction
	task automatic frame(input logic [1:0] m, input logic [1:0] er);
		crit = m;
		ov = er[0];
		berr = er[1];
		ld = 1'h1;
		tick();
		ld = 1'h0;
		repeat (8) tick();
		sn = 0;
		tok = 1'h1;
		repeat (3) tick();
		tok = 1'h0;
		k = 0;
		while (done !== 1'h1 && k < 2000) begin
			tick();
			k++;
		end
		check("frame", sbuf, exp_frame(m, er[1] ? 3'h4 : {1'h0, er[0], 1'h0}));
		check("done", {63'h0, done}, 64'h1);
		ov = 1'h0;
		berr = 1'h0;
		repeat (4) tick();
	endtask
	initial begin
		repeat (6000) @(posedge clk);
		failures++;
		print_verdict();
	end
	// Main sequence
	initial begin
		{rst_n, soft_n, cr, trig, role, ld, tok, ov, berr, crit} = '0;
		clr_n = 1'h1;
		w0 = '0;
		w1 = '0;
		w2 = '0;
		{w0[6], w0[20], w1[5], w1[6], w2[127]} = 5'h1f;
		sn = 64;
		on = 26;
		failures = 0;
		cmp_count = 0;
		repeat (16) tick();
		rst_n = 1'h1;
		tick();
		tok = 1'h1;
		k = 0;
		while (tout !== 1'h1 && k < 20) begin
			tick();
			k++;
		end
		check("pass", {62'h0, tout, done}, 64'h3);
		check("pass_lat", {63'h0, k <= 6}, 64'h1);
		check("pass_quiet", sn, 64);
		tok = 1'h0;
		repeat (4) tick();
		for (int m = 0; m < 4; m++) frame(m[1:0], 2'h0);
		frame(2'h0, 2'h1);
		frame(2'h0, 2'h3);
		trig = 1'h1;
		tick();
		trig = 1'h0;
		repeat (6) tick();
		role = 1'h1;
		soft_n = 1'h0;
		cr = 1'h1;
		tick();
		soft_n = 1'h1;
		on = 0;
		tick();
		cr = 1'h0;
		repeat (37) tick();
		trig = 1'h1;
		tick();
		trig = 1'h0;
		repeat (2) tick();
		trig = 1'h1;
		tick();
		trig = 1'h0;
		k = 0;
		while (on < 26 && k < 600) begin
			tick();
			k++;
		end
		check("tags", {38'h0, obuf}, {38'h0, 1'h1, 4'h0, 8'h25, 1'h1, 4'h1, 8'h28});
		role = 1'h0;
		repeat (20) tick();
		print_verdict();
	end
endmodule // test_sparse_hit_readout_chain
